// *** adcb_ctrl.sv ***
// Converter control, result format, boundary compare and start delay
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module adcb_ctrl #(
  parameter int RES_W = 12,
  parameter int DLY_W = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger from PWM logic
  input  wire logic        pwm_trig,
  // Converter core
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic             conv_power,
  output logic             conv_start,
  output logic             conv_clk_en,
  // Input multiplexer and pins
  output logic      [3:0]  chan_sel,
  output logic             chan_connect,
  output logic             opamp_sel,
  output logic             ground_sel,
  output logic      [9:0]  pin_analog_mode,
  // Configuration to PWM interrupt logic and compare event
  output logic      [2:0]  pwm_int_cfg,
  output logic             cmp_event
);

  if (RES_W != 12 || DLY_W != 8) begin : g_chk
    $error("adcb_ctrl supports only RES_W 12 and DLY_W 8");
  end

  typedef struct packed {
    logic              start;
    logic              en;
    logic              fmt;
    logic [3:0]        chan;
    logic [2:0]        src;
    logic [2:0]        cks;
    logic              trig;
    logic              dlen;
    logic              pwis;
    logic [1:0]        cmode;
    logic [1:0]        pwdis;
    logic [7:0]        dly;
    logic [11:0]       lo;
    logic [11:0]       hi;
    logic [11:0]       res;
    adcb_pkg::adcb_fsm_t fsm;
    logic [7:0]        dcnt;
    logic [6:0]        div;
    logic              cke;
    logic              go;
    logic              cmp;
    logic [31:0]       rdata;
    logic              err;
  } adcb_state_t;

  adcb_state_t st_ff;
  adcb_state_t nxt_st;

  logic        setup;
  logic        wr_acc;
  logic        launch_sw;
  logic        int_src;
  logic        hit;
  logic [6:0]  div_mask;

  // ****************************************
  // Byte views of twelve-bit values
  // ****************************************
  function automatic logic [7:0] get_byte(input logic [11:0] v,
                                          input logic f,
                                          input logic hb);
    if (hb)
      return f ? {4'h0, v[11:8]} : v[11:4];
    return f ? v[7:0] : {v[3:0], 4'h0};
  endfunction

  function automatic logic [11:0] put_byte(input logic [11:0] v,
                                           input logic f,
                                           input logic hb,
                                           input logic [7:0] b);
    if (hb)
      return f ? {b[3:0], v[7:0]} : {b, v[3:0]};
    return f ? {v[11:8], b} : {v[11:4], b[7:4]};
  endfunction

  // ****************************************
  // Combinational helpers
  // ****************************************
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  // Launch only on the falling write of a previously set start bit
  assign launch_sw = wr_acc && paddr == adcb_pkg::A_CTRL0 &&
                     st_ff.start && !pwdata[adcb_pkg::C0_START] &&
                     !st_ff.trig;
  assign int_src = st_ff.src == adcb_pkg::SRC_OPAMP ||
                   st_ff.src == adcb_pkg::SRC_GND_A ||
                   st_ff.src == adcb_pkg::SRC_GND_B;
  assign div_mask = 7'((8'h1 << st_ff.cks) - 8'h1);

  always_comb begin
    hit = 1'b0;
    case (adcb_pkg::adcb_cmp_t'(st_ff.cmode))
      adcb_pkg::CMP_INSIDE:
        hit = st_ff.lo < conv_data && conv_data < st_ff.hi;
      adcb_pkg::CMP_AT_LOW:  hit = conv_data <= st_ff.lo;
      adcb_pkg::CMP_AT_HIGH: hit = conv_data >= st_ff.hi;
      default: hit = conv_data <= st_ff.lo || conv_data >= st_ff.hi;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.go  = 1'b0;
    nxt_st.cmp = 1'b0;
    nxt_st.cke = 1'b0;
    // Free divider; a tick marks one converter clock
    if (st_ff.en) begin
      nxt_st.div = st_ff.div + 7'h1;
      nxt_st.cke = (st_ff.div & div_mask) == div_mask;
    end
    // Read data is captured in setup so prdata is a flop
    if (setup) begin
      nxt_st.rdata = 32'h0;
      nxt_st.err   = 1'b0;
      if (paddr == adcb_pkg::A_RES_LO)
        nxt_st.rdata[7:0] = get_byte(st_ff.res, st_ff.fmt, 1'b0);
      else if (paddr == adcb_pkg::A_RES_HI)
        nxt_st.rdata[7:0] = get_byte(st_ff.res, st_ff.fmt, 1'b1);
      else if (paddr == adcb_pkg::A_LBD_LO)
        nxt_st.rdata[7:0] = get_byte(st_ff.lo, st_ff.fmt, 1'b0);
      else if (paddr == adcb_pkg::A_LBD_HI)
        nxt_st.rdata[7:0] = get_byte(st_ff.lo, st_ff.fmt, 1'b1);
      else if (paddr == adcb_pkg::A_HBD_LO)
        nxt_st.rdata[7:0] = get_byte(st_ff.hi, st_ff.fmt, 1'b0);
      else if (paddr == adcb_pkg::A_HBD_HI)
        nxt_st.rdata[7:0] = get_byte(st_ff.hi, st_ff.fmt, 1'b1);
      else if (paddr == adcb_pkg::A_CTRL0)
        nxt_st.rdata[7:0] = {st_ff.start, st_ff.fsm != adcb_pkg::ST_IDLE,
                             st_ff.en, st_ff.fmt, st_ff.chan};
      else if (paddr == adcb_pkg::A_CTRL1)
        nxt_st.rdata[7:0] = {st_ff.src, 2'b00, st_ff.cks};
      else if (paddr == adcb_pkg::A_CTRL2)
        nxt_st.rdata[7:0] = {st_ff.trig, st_ff.dlen, st_ff.pwis,
                             st_ff.cmode, 1'b0, st_ff.pwdis};
      else if (paddr == adcb_pkg::A_DELAY)
        nxt_st.rdata[7:0] = st_ff.dly;
      else
        nxt_st.err = 1'b1;
    end
    // Writes land at the access edge; result addresses ignore them
    if (wr_acc) begin
      if (paddr == adcb_pkg::A_LBD_LO)
        nxt_st.lo = put_byte(st_ff.lo, st_ff.fmt, 1'b0, pwdata[7:0]);
      else if (paddr == adcb_pkg::A_LBD_HI)
        nxt_st.lo = put_byte(st_ff.lo, st_ff.fmt, 1'b1, pwdata[7:0]);
      else if (paddr == adcb_pkg::A_HBD_LO)
        nxt_st.hi = put_byte(st_ff.hi, st_ff.fmt, 1'b0, pwdata[7:0]);
      else if (paddr == adcb_pkg::A_HBD_HI)
        nxt_st.hi = put_byte(st_ff.hi, st_ff.fmt, 1'b1, pwdata[7:0]);
      else if (paddr == adcb_pkg::A_CTRL0) begin
        nxt_st.start = pwdata[adcb_pkg::C0_START];
        nxt_st.en    = pwdata[adcb_pkg::C0_EN];
        nxt_st.fmt   = pwdata[adcb_pkg::C0_FMT];
        nxt_st.chan  = pwdata[3:0];
      end else if (paddr == adcb_pkg::A_CTRL1) begin
        nxt_st.src = pwdata[adcb_pkg::C1_SRC +: 3];
        nxt_st.cks = pwdata[2:0];
      end else if (paddr == adcb_pkg::A_CTRL2) begin
        nxt_st.trig  = pwdata[adcb_pkg::C2_TRIG];
        nxt_st.dlen  = pwdata[adcb_pkg::C2_DLEN];
        nxt_st.pwis  = pwdata[adcb_pkg::C2_PWIS];
        nxt_st.cmode = pwdata[adcb_pkg::C2_HVE:adcb_pkg::C2_LVE];
        nxt_st.pwdis = pwdata[1:0];
      end else if (paddr == adcb_pkg::A_DELAY)
        nxt_st.dly = pwdata[7:0];
    end
    // Conversion sequencing
    case (st_ff.fsm)
      adcb_pkg::ST_IDLE: begin
        if (st_ff.en && launch_sw) begin
          nxt_st.fsm = adcb_pkg::ST_BUSY;
          nxt_st.go  = 1'b1;
        end else if (st_ff.en && st_ff.trig && pwm_trig) begin
          if (st_ff.dlen && st_ff.dly != 8'h00) begin
            nxt_st.fsm  = adcb_pkg::ST_WAIT;
            nxt_st.dcnt = st_ff.dly;
          end else begin
            nxt_st.fsm = adcb_pkg::ST_BUSY;
            nxt_st.go  = 1'b1;
          end
        end
      end
      adcb_pkg::ST_WAIT: begin
        nxt_st.dcnt = st_ff.dcnt - 8'h1;
        if (st_ff.dcnt == 8'h01) begin
          nxt_st.fsm = adcb_pkg::ST_BUSY;
          nxt_st.go  = 1'b1;
        end
      end
      adcb_pkg::ST_BUSY: begin
        if (conv_done) begin
          nxt_st.res = conv_data;
          nxt_st.fsm = adcb_pkg::ST_IDLE;
          nxt_st.cmp = hit;
        end
      end
      default: nxt_st.fsm = adcb_pkg::ST_IDLE;
    endcase
    // Disabled converter: results cleared, bounds untouched
    if (!st_ff.en) begin
      nxt_st.res  = 12'h000;
      nxt_st.fsm  = adcb_pkg::ST_IDLE;
      nxt_st.go   = 1'b0;
      nxt_st.cmp  = 1'b0;
      nxt_st.div  = 7'h00;
      nxt_st.dcnt = adcb_pkg::RST_REG;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready      = psel & penable;
  assign prdata      = st_ff.rdata;
  assign pslverr     = pready & st_ff.err;
  assign conv_power  = st_ff.en;
  assign conv_start  = st_ff.go;
  assign conv_clk_en = st_ff.cke;
  assign cmp_event   = st_ff.cmp;
  assign pwm_int_cfg = {st_ff.pwis, st_ff.pwdis};
  assign chan_sel    = st_ff.chan;
  assign opamp_sel   = st_ff.en && st_ff.src == adcb_pkg::SRC_OPAMP;
  assign ground_sel  = st_ff.en && int_src && !opamp_sel;
  // Internal source wins over any channel code
  assign chan_connect = st_ff.en && !int_src &&
                        st_ff.chan < 4'(adcb_pkg::NUM_CHAN);

  for (genvar i = 0; i < adcb_pkg::NUM_CHAN; i++) begin : g_pin
    // Analog pin: digital path and pullup are released
    assign pin_analog_mode[i] = chan_connect &&
                                st_ff.chan == 4'(i);
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_start_drop;
    st_ff.en && !st_ff.trig && st_ff.fsm == adcb_pkg::ST_IDLE &&
    st_ff.start ##1 !st_ff.start;
  endsequence

  sequence s_rd_setup(logic [7:0] a);
    setup && !pwrite && paddr == a;
  endsequence

  AST_START_SEQ: assert property (s_start_drop |->
    st_ff.fsm == adcb_pkg::ST_BUSY && conv_start)
    else $error("start drop did not launch");
  AST_BUSY_SET: assert property (conv_start |->
    st_ff.fsm == adcb_pkg::ST_BUSY)
    else $error("busy missing at launch");
  AST_DONE: assert property (st_ff.en && st_ff.fsm == adcb_pkg::ST_BUSY &&
    conv_done |=> st_ff.fsm == adcb_pkg::ST_IDLE &&
    st_ff.res == $past(conv_data))
    else $error("result and busy not updated together");
  AST_DIS_CLR: assert property (!st_ff.en |=> st_ff.res == 12'h000)
    else $error("result not cleared when disabled");
  AST_BOUND_KEEP: assert property ($fell(st_ff.en) |->
    st_ff.lo == $past(st_ff.lo) && st_ff.hi == $past(st_ff.hi))
    else $error("boundary changed on disable");
  AST_FMT0_LO: assert property (s_rd_setup(adcb_pkg::A_RES_LO) &&
    !st_ff.fmt |=> prdata[3:0] == 4'h0 && prdata[7:4] == $past(st_ff.res[3:0]))
    else $error("format 0 low byte wrong");
  AST_FMT1_HI: assert property (s_rd_setup(adcb_pkg::A_RES_HI) &&
    st_ff.fmt |=> prdata[31:4] == 28'h0 &&
    prdata[3:0] == $past(st_ff.res[11:8]))
    else $error("format 1 high byte wrong");
  AST_DELAY: assert property (st_ff.fsm == adcb_pkg::ST_IDLE &&
    st_ff.en && st_ff.trig && st_ff.dlen && st_ff.dly == 8'h02 &&
    pwm_trig |=> !conv_start [*2] ##1 conv_start)
    else $error("delayed start mistimed");
  AST_CMP: assert property (st_ff.en && st_ff.fsm == adcb_pkg::ST_BUSY &&
    conv_done |=> cmp_event == $past(hit))
    else $error("compare event wrong");
  AST_MUX: assert property (int_src |-> !chan_connect &&
    pin_analog_mode == 10'h000)
    else $error("external channel left on with internal source");
  AST_RSV: assert property (st_ff.chan >= 4'ha |-> !chan_connect)
    else $error("reserved channel connected");

endmodule // adcb_ctrl

// *** adcb_pkg.sv ***
// Shared constants for the converter control and result block
package adcb_pkg;

  // ****************************************
  // Register byte addresses on APB
  // ****************************************
  localparam logic [7:0] A_RES_LO  = 8'h00;
  localparam logic [7:0] A_RES_HI  = 8'h04;
  localparam logic [7:0] A_LBD_LO  = 8'h08;
  localparam logic [7:0] A_LBD_HI  = 8'h0c;
  localparam logic [7:0] A_HBD_LO  = 8'h10;
  localparam logic [7:0] A_HBD_HI  = 8'h14;
  localparam logic [7:0] A_CTRL0   = 8'h18;
  localparam logic [7:0] A_CTRL1   = 8'h1c;
  localparam logic [7:0] A_CTRL2   = 8'h20;
  localparam logic [7:0] A_DELAY   = 8'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C0_START  = 7;
  localparam int C0_BUSY   = 6;
  localparam int C0_EN     = 5;
  localparam int C0_FMT    = 4;
  localparam int C1_SRC    = 5;
  localparam int C2_TRIG   = 7;
  localparam int C2_DLEN   = 6;
  localparam int C2_PWIS   = 5;
  localparam int C2_HVE    = 4;
  localparam int C2_LVE    = 3;

  // ****************************************
  // Reset value and encodings
  // ****************************************
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam int         NUM_CHAN  = 10;
  localparam logic [2:0] SRC_OPAMP = 3'h1;
  localparam logic [2:0] SRC_GND_A = 3'h2;
  localparam logic [2:0] SRC_GND_B = 3'h3;

  typedef enum logic [1:0] {
    CMP_INSIDE  = 2'b00,
    CMP_AT_LOW  = 2'b01,
    CMP_AT_HIGH = 2'b10,
    CMP_OUTSIDE = 2'b11
  } adcb_cmp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BUSY = 2'b10
  } adcb_fsm_t;

endpackage

// *** adcb_core_model.sv ***
// Behavioural model of the converter core behind the control block
`timescale 1ns/1ps
module adcb_core_model #(
  parameter int LAT = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Control from the block
  input  wire logic        conv_start,
  input  wire logic        conv_power,
  // Value the next conversion returns
  input  wire logic [11:0] value,
  // Result to the block
  output logic             conv_done,
  output logic      [11:0] conv_data
);
  logic [7:0] cnt_ff;

  always_ff @(posedge core_clk) begin
    if (rst || !conv_power) begin
      cnt_ff    <= 8'h00;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
    end else begin
      conv_done <= (cnt_ff == 8'h01);
      // Data only holds with done; toggles otherwise to catch stale use
      conv_data <= (cnt_ff == 8'h01) ? value : ~conv_data;
      if (conv_start)
        cnt_ff <= LAT[7:0];
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule // adcb_core_model

// *** adcb_ctrl_bench.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module adcb_ctrl_bench;
  logic        core_clk, rst, psel, penable, pwrite, pwm_trig;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, conv_done, conv_power, conv_start;
  logic        conv_clk_en, chan_connect, opamp_sel, ground_sel, cmp_event;
  logic [11:0] conv_data, val;
  logic [3:0]  chan_sel;
  logic [9:0]  pin_am;
  logic [2:0]  pwm_cfg;
  int          n_mismatch, checks, n_evt, e0, n;
  // Compare table: mode, expected event, result value
  localparam logic [15:0] CT [8] = '{16'h1400, 16'h0800, 16'h5200,
    16'h4201, 16'h9800, 16'h87ff, 16'hd100, 16'hc400};

  adcb_ctrl adcb_ctrl_i (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_trig(pwm_trig), .conv_done(conv_done), .conv_data(conv_data),
    .conv_power(conv_power), .conv_start(conv_start),
    .conv_clk_en(conv_clk_en), .chan_sel(chan_sel),
    .chan_connect(chan_connect), .opamp_sel(opamp_sel),
    .ground_sel(ground_sel), .pin_analog_mode(pin_am),
    .pwm_int_cfg(pwm_cfg),
    .cmp_event(cmp_event));

  adcb_core_model adcb_core_model_i (.core_clk(core_clk), .rst(rst),
    .conv_start(conv_start), .conv_power(conv_power), .value(val),
    .conv_done(conv_done), .conv_data(conv_data));

  // ****************************************
  // Clock, watchdog and event count
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end

  always @(posedge core_clk) begin
    if (cmp_event === 1'b1)
      n_evt++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // Poll until busy drops, bounded
  task automatic idle();
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, adcb_pkg::A_CTRL0, 8'h00);
      if (rd[6] !== 1'b1)
        break;
    end
  endtask

  task automatic conv(input logic [11:0] v, input logic [7:0] c);
    val <= v;
    apb(1'b1, adcb_pkg::A_CTRL0, c | 8'h80);
    apb(1'b1, adcb_pkg::A_CTRL0, c);
    idle();
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pwm_trig = 1'b0;
    val = 12'h000;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdc(adcb_pkg::A_CTRL0, adcb_pkg::RST_REG);
    apb(1'b0, 8'hfc, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset and unmapped done");
    val <= 12'habc;
    apb(1'b1, adcb_pkg::A_CTRL0, 8'ha0);
    apb(1'b0, adcb_pkg::A_CTRL0, 8'h00);
    chk({31'h0, rd[6]}, 32'h0);
    apb(1'b1, adcb_pkg::A_CTRL0, 8'h20);
    apb(1'b0, adcb_pkg::A_CTRL0, 8'h00);
    chk({31'h0, rd[6]}, 32'h1);
    idle();
    chk({31'h0, rd[6]}, 32'h0);
    rdc(adcb_pkg::A_RES_HI, 8'hab);
    rdc(adcb_pkg::A_RES_LO, 8'hc0);
    apb(1'b1, adcb_pkg::A_CTRL0, 8'h30);
    rdc(adcb_pkg::A_RES_HI, 8'h0a);
    rdc(adcb_pkg::A_RES_LO, 8'hbc);
    apb(1'b1, adcb_pkg::A_RES_LO, 8'h55);
    rdc(adcb_pkg::A_RES_LO, 8'hbc);
    $display("test start and format done");
    apb(1'b1, adcb_pkg::A_HBD_HI, 8'h08);
    apb(1'b1, adcb_pkg::A_HBD_LO, 8'h00);
    apb(1'b1, adcb_pkg::A_LBD_HI, 8'h02);
    apb(1'b1, adcb_pkg::A_LBD_LO, 8'h00);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, adcb_pkg::A_CTRL2, {3'h0, CT[i][15:14], 3'h0});
      e0 = n_evt;
      conv(CT[i][11:0], 8'h30);
      chk(n_evt - e0, {31'h0, CT[i][12]});
    end
    apb(1'b1, adcb_pkg::A_CTRL0, 8'h20);
    rdc(adcb_pkg::A_HBD_HI, 8'h80);
    rdc(adcb_pkg::A_LBD_LO, 8'h00);
    $display("test boundaries done");
    apb(1'b1, adcb_pkg::A_CTRL0, 8'h10);
    @(negedge core_clk);
    chk({31'h0, conv_power}, 32'h0);
    rdc(adcb_pkg::A_RES_HI, 8'h00);
    rdc(adcb_pkg::A_RES_LO, 8'h00);
    rdc(adcb_pkg::A_HBD_HI, 8'h08);
    rdc(adcb_pkg::A_LBD_HI, 8'h02);
    $display("test disable done");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, adcb_pkg::A_CTRL0, {4'h2, c[3:0]});
      // Outputs settle after the access edge
      @(negedge core_clk);
      chk({31'h0, chan_connect}, {31'h0, c <= 9});
      chk({18'h0, chan_sel, pin_am},
          {18'h0, c[3:0], (c <= 9) ? (10'h001 << c) : 10'h000});
    end
    apb(1'b1, adcb_pkg::A_CTRL0, 8'h20);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, adcb_pkg::A_CTRL1, {s[2:0], 5'h00});
      @(negedge core_clk);
      chk({opamp_sel, ground_sel, chan_connect},
          {s == 1, s == 2 || s == 3, s == 0 || s > 3});
    end
    apb(1'b1, adcb_pkg::A_CTRL2, 8'h22);
    @(negedge core_clk);
    chk({29'h0, pwm_cfg}, 32'h6);
    apb(1'b1, adcb_pkg::A_CTRL1, 8'h03);
    // Skip the tick still computed with the old divide code
    @(posedge core_clk);
    @(negedge core_clk);
    for (int i = 0; i < 20 && conv_clk_en !== 1'b1; i++)
      @(negedge core_clk);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_clk_en !== 1'b1 && n < 20);
    chk(n, 32'd8);
    $display("test routing and clock done");
    for (int d = 0; d < 3; d += 2) begin
      // Delay value is set before its enable, zero when disabled
      apb(1'b1, adcb_pkg::A_DELAY, d[7:0]);
      apb(1'b1, adcb_pkg::A_CTRL2, d > 0 ? 8'hc0 : 8'h80);
      @(posedge core_clk);
      pwm_trig <= 1'b1;
      @(posedge core_clk);
      pwm_trig <= 1'b0;
      for (n = 1; n < 40; n++) begin
        @(negedge core_clk);
        if (conv_start === 1'b1)
          break;
      end
      chk(n, d + 1);
      idle();
      chk({31'h0, rd[6]}, 32'h0);
    end
    $display("test delayed trigger done");
    give_verdict();
  end
endmodule // adcb_ctrl_bench
